/* File: dps_addr_match.sv */
// Purpose: Address compare for one strobe pin
// Assumes: Length code per compare-length field
// Notes:   Combinational
`timescale 1ns/1ps
module dps_addr_match
  import dps_pkg::*;
(
  input  wire logic [15:0] base_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [1:0]  len_i,
  output logic             hit_o
);
  logic [15:0] mask;
  // Low bits ignored per length code
  assign mask = (len_i == 2'b00) ? 16'hffff :
                (len_i == 2'b01) ? 16'hfffe :
                (len_i == 2'b10) ? 16'hfffc : 16'hff00;
  assign hit_o = ((base_i ^ addr_i) & mask) == 16'h0000;
endmodule : dps_addr_match

/* File: dps_checker.sv */
// Purpose: Port checks for dps_top
// Assumes: Shadow of aux bit 0 and port-2 function
// Notes:   Bound to the top module
`timescale 1ns/1ps
module dps_checker
  import dps_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       ext_rd_i,
  input wire logic       ext_wr_i,
  input wire logic       ext_hit_o,
  input wire logic       ext_code_i,
  input wire logic       ale_i,
  input wire logic       ale_o,
  input wire logic [7:0] port2_std_i,
  input wire logic [7:0] port2_pins_o,
  input wire logic [7:0] port2_pins_oe_n_o
);
  logic       sup;
  logic [1:0] pf;
  wire        wr_ok = ce_i && sfr_wr_i;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sup <= 1'b0;
      pf  <= 2'b00;
    end else begin
      if (wr_ok && sfr_addr_i == DPS_AUX_CTRL_ADDR) sup <= sfr_wdata_i[0];
      if (wr_ok && sfr_addr_i == DPS_P2_EXT_CTRL_ADDR) pf <= sfr_wdata_i[1:0];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence ext_s;
    ext_rd_i || ext_wr_i || ext_code_i;
  endsequence
  sequence rd_s(a);
    ce_i && sfr_rd_i && sfr_addr_i == a;
  endsequence
  ale_pass_a: assert property (
    ce_i && !sup |=> ale_o == $past(ale_i)) else $error("ale lost");
  ale_gate_a: assert property (
    ce_i && sup && !(ext_rd_i || ext_wr_i || ext_code_i) |=> !ale_o)
    else $error("ale not off");
  ale_wake_a: assert property (
    ce_i && sup ##0 ext_s |=> ale_o == $past(ale_i)) else $error("ale off");
  aux_read_a: assert property (
    rd_s(DPS_AUX_CTRL_ADDR) |=> sfr_rdata_o == {7'h00, $past(sup)})
    else $error("aux read");
  data_rsvd_a: assert property (
    rd_s(DPS_PORT_DATA_ADDR) |=> sfr_rdata_o[7:4] == 4'h0)
    else $error("data upper bits");
  ctrl_rsvd_a: assert property (
    rd_s(DPS_P2_EXT_CTRL_ADDR) |=> sfr_rdata_o[3:0] == {2'b00, $past(pf)})
    else $error("ctrl read");
  p2_std_a: assert property (
    ce_i && pf == 2'b00 |=> port2_pins_o == $past(port2_std_i))
    else $error("std port");
  p2_buf_a: assert property (
    ce_i && pf == 2'b01 |=> port2_pins_oe_n_o == 8'hff)
    else $error("buffer drives");
  hit_mode_a: assert property (
    ce_i && (pf != 2'b01 || !ext_rd_i) |=> !ext_hit_o)
    else $error("stray hit");
endmodule : dps_checker
bind dps_top dps_checker u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
  .ext_rd_i(ext_rd_i), .ext_wr_i(ext_wr_i), .ext_hit_o(ext_hit_o),
  .ext_code_i(ext_code_i), .ale_i(ale_i), .ale_o(ale_o),
  .port2_std_i(port2_std_i), .port2_pins_o(port2_pins_o),
  .port2_pins_oe_n_o(port2_pins_oe_n_o));

/* File: dps_periph.sv */
// Purpose: Peripheral side of port 2 and strobe pins
// Assumes: Strobe pins pulled up when released
// Notes:   Drives a fixed byte into released port 2
`timescale 1ns/1ps
module dps_periph #(
  parameter logic [7:0] BUF_DATA = 8'h3c
) (
  input  wire logic [7:0] p2_oe_n_i,
  input  wire logic [7:0] p2_o_i,
  input  wire logic [3:0] stb_oe_n_i,
  input  wire logic [3:0] stb_o_i,
  output logic      [7:0] p2_lvl_o,
  output logic      [3:0] stb_lvl_o
);
  assign p2_lvl_o  = (p2_oe_n_i & BUF_DATA) | (~p2_oe_n_i & p2_o_i);
  assign stb_lvl_o = stb_oe_n_i | stb_o_i;
endmodule : dps_periph

/* File: dps_pkg.sv */
// Purpose: Constants for the decoded port chip-select block
// Assumes: 8-bit special function register space, 16-bit bus address
// Notes:   Offsets are special function register addresses
package dps_pkg;
  localparam logic [7:0] DPS_AUX_CTRL_ADDR    = 8'h8e;
  localparam logic [7:0] DPS_P2_EXT_CTRL_ADDR = 8'hae;
  localparam logic [7:0] DPS_FUNC_LOW_ADDR    = 8'hc2;
  localparam logic [7:0] DPS_FUNC_HIGH_ADDR   = 8'hc3;
  localparam logic [7:0] DPS_PORT_DATA_ADDR   = 8'hd8;
  localparam logic [7:0] DPS_P2_ADDR_HIGH     = 8'ha7;
  localparam logic [7:0] DPS_P2_ADDR_LOW      = 8'ha6;
  localparam logic [7:0] DPS_P2_DATA_ADDR     = 8'ha0;
  localparam logic [7:0] DPS_BASE_HIGH_ADDR0  = 8'h85;
  localparam logic [7:0] DPS_BASE_LOW_ADDR0   = 8'h84;
  localparam logic [7:0] DPS_BASE_HIGH_ADDR1  = 8'h95;
  localparam logic [7:0] DPS_BASE_LOW_ADDR1   = 8'h94;
  localparam logic [7:0] DPS_BASE_HIGH_ADDR2  = 8'had;
  localparam logic [7:0] DPS_BASE_LOW_ADDR2   = 8'hac;
  localparam logic [7:0] DPS_BASE_HIGH_ADDR3  = 8'hb5;
  localparam logic [7:0] DPS_BASE_LOW_ADDR3   = 8'hb4;
  localparam int         DPS_SUPPRESS_BIT     = 0;
  localparam int         DPS_POLARITY_LSB     = 4;
  localparam int         DPS_P2FUNC_LSB       = 0;
  localparam logic [7:0] DPS_REG_RESET        = 8'h00;
  localparam logic [7:0] DPS_P2_DATA_RESET    = 8'hff;
  localparam logic [3:0] DPS_PORT_DATA_RESET  = 4'hf;
  localparam logic [7:0] DPS_P2_EXT_MASK      = 8'hf3;
  localparam logic [7:0] DPS_AUX_MASK         = 8'h01;
  typedef enum logic [1:0] {
    DPS_PIN_GPIO  = 2'b00,
    DPS_PIN_READ  = 2'b01,
    DPS_PIN_WRITE = 2'b10,
    DPS_PIN_RDWR  = 2'b11
  } dps_pin_mode_t;
  typedef enum logic [1:0] {
    DPS_P2_STD    = 2'b00,
    DPS_P2_BUFFER = 2'b01,
    DPS_P2_LATCH  = 2'b10,
    DPS_P2_UNDEF  = 2'b11
  } dps_p2_func_t;
endpackage : dps_pkg

/* File: dps_top.sv */
// Purpose: Decoded strobe port and address-enabled port 2 extension
// Assumes: Single-cycle register bus and external access qualifiers
// Notes:   Pins use input, output and active-low output enable
`timescale 1ns/1ps
module dps_top
  import dps_pkg::*;
#(
  parameter int NPINS = 4
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [7:0]       sfr_addr_i,
  input  wire logic [7:0]       sfr_wdata_i,
  input  wire logic             sfr_wr_i,
  input  wire logic             sfr_rd_i,
  output logic      [7:0]       sfr_rdata_o,
  input  wire logic [15:0]      ext_addr_i,
  input  wire logic [7:0]       ext_wdata_i,
  input  wire logic             ext_rd_i,
  input  wire logic             ext_wr_i,
  output logic      [7:0]       ext_rdata_o,
  output logic                  ext_hit_o,
  input  wire logic             ext_code_i,
  input  wire logic             ale_i,
  output logic                  ale_o,
  input  wire logic [NPINS-1:0] strobe_pin_i,
  output logic      [NPINS-1:0] strobe_pin_o,
  output logic      [NPINS-1:0] strobe_pin_oe_n_o,
  output logic      [1:0]       ext_int_o,
  input  wire logic [7:0]       port2_pins_i,
  input  wire logic [7:0]       port2_std_i,
  output logic      [7:0]       port2_pins_o,
  output logic      [7:0]       port2_pins_oe_n_o
);
  logic [7:0]       auxiliary_control;
  logic [7:0]       port2_extension_control;
  logic [7:0]       strobe_pins_low_function;
  logic [7:0]       strobe_pins_high_function;
  logic [3:0]       strobe_port_data;
  logic [7:0]       port2_enable_address_high;
  logic [7:0]       port2_enable_address_low;
  logic [7:0]       port2_data;
  logic [7:0]       port2_latch;
  logic [7:0]       base_high [NPINS];
  logic [7:0]       base_low  [NPINS];
  logic [NPINS-1:0] pin_hit;
  logic [NPINS-1:0] next_strobe_pin;
  logic [NPINS-1:0] next_strobe_oe_n;
  logic [NPINS-1:0] base_high_sel;
  logic [NPINS-1:0] base_low_sel;
  logic [7:0]       next_rdata;
  logic [7:0]       next_p2_pins;
  logic [7:0]       next_p2_oe_n;
  logic             p2_addr_hit;
  logic             next_ale;
  logic [1:0]       p2_func;
  logic [15:0]      p2_enable_addr;
  logic [7:0]       base_high_rd;
  logic [7:0]       base_low_rd;
  logic             ext_access;
  logic             p2_latch_load;

  assign p2_func        = port2_extension_control[DPS_P2FUNC_LSB +: 2];
  assign p2_enable_addr = {port2_enable_address_high,
                           port2_enable_address_low};
  assign p2_addr_hit    = (ext_addr_i == p2_enable_addr);
  assign ext_access     = ext_rd_i | ext_wr_i;
  assign p2_latch_load  = (p2_func == DPS_P2_LATCH) & ext_wr_i & p2_addr_hit;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      logic [1:0] mode;
      logic [1:0] len;
      logic       act;
      logic       pol;
      // Pins 0 and 1 in the low register, 2 and 3 in the high one
      if (g < 2) begin : g_lo
        assign mode = strobe_pins_low_function[4*g+2 +: 2];
        assign len  = strobe_pins_low_function[4*g +: 2];
      end else begin : g_hi
        assign mode = strobe_pins_high_function[4*(g-2)+2 +: 2];
        assign len  = strobe_pins_high_function[4*(g-2) +: 2];
      end
      assign pol  = port2_extension_control[DPS_POLARITY_LSB+g];
      dps_addr_match u_match (
        .base_i (({base_high[g], base_low[g]})),
        .addr_i (ext_addr_i),
        .len_i  (len),
        .hit_o  (pin_hit[g])
      );
      // Strobe active for the matched access kind
      assign act = pin_hit[g] &
                   ((mode == DPS_PIN_READ  & ext_rd_i) |
                    (mode == DPS_PIN_WRITE & ext_wr_i) |
                    (mode == DPS_PIN_RDWR  & ext_access));
      assign next_strobe_pin[g] = (mode == DPS_PIN_GPIO)
                                ? strobe_port_data[g]
                                : (act ~^ pol);
      // Mode zero: quasi-bidirectional, released when data is one
      assign next_strobe_oe_n[g] = (mode == DPS_PIN_GPIO)
                                 ? strobe_port_data[g] : 1'b0;
      assign base_high_sel[g] = sfr_wr_i & (sfr_addr_i ==
        (g == 0 ? DPS_BASE_HIGH_ADDR0 : g == 1 ? DPS_BASE_HIGH_ADDR1 :
         g == 2 ? DPS_BASE_HIGH_ADDR2 : DPS_BASE_HIGH_ADDR3));
      assign base_low_sel[g]  = sfr_wr_i & (sfr_addr_i ==
        (g == 0 ? DPS_BASE_LOW_ADDR0 : g == 1 ? DPS_BASE_LOW_ADDR1 :
         g == 2 ? DPS_BASE_LOW_ADDR2 : DPS_BASE_LOW_ADDR3));
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          base_high[g] <= DPS_REG_RESET;
          base_low[g]  <= DPS_REG_RESET;
        end else if (ce_i) begin
          if (base_high_sel[g]) base_high[g] <= sfr_wdata_i;
          if (base_low_sel[g])  base_low[g]  <= sfr_wdata_i;
        end
      end
    end
  endgenerate

  // Base register readback
  always_comb begin
    base_high_rd = 8'h00;
    base_low_rd  = 8'h00;
    for (int i = 0; i < NPINS; i++) begin
      if (sfr_addr_i == (i == 0 ? DPS_BASE_HIGH_ADDR0 :
          i == 1 ? DPS_BASE_HIGH_ADDR1 : i == 2 ? DPS_BASE_HIGH_ADDR2 :
          DPS_BASE_HIGH_ADDR3)) base_high_rd = base_high[i];
      if (sfr_addr_i == (i == 0 ? DPS_BASE_LOW_ADDR0 :
          i == 1 ? DPS_BASE_LOW_ADDR1 : i == 2 ? DPS_BASE_LOW_ADDR2 :
          DPS_BASE_LOW_ADDR3)) base_low_rd = base_low[i];
    end
  end

  assign next_rdata =
    (sfr_addr_i == DPS_AUX_CTRL_ADDR)    ? auxiliary_control :
    (sfr_addr_i == DPS_P2_EXT_CTRL_ADDR) ? port2_extension_control :
    (sfr_addr_i == DPS_FUNC_LOW_ADDR)    ? strobe_pins_low_function :
    (sfr_addr_i == DPS_FUNC_HIGH_ADDR)   ? strobe_pins_high_function :
    (sfr_addr_i == DPS_PORT_DATA_ADDR)   ? {4'h0, strobe_pin_i} :
    (sfr_addr_i == DPS_P2_ADDR_HIGH)     ? port2_enable_address_high :
    (sfr_addr_i == DPS_P2_ADDR_LOW)      ? port2_enable_address_low :
    (sfr_addr_i == DPS_P2_DATA_ADDR)     ? port2_data :
    base_high_rd | base_low_rd;

  // Port 2 pins per function
  assign next_p2_pins =
    (p2_func == DPS_P2_STD)   ? port2_std_i :
    (p2_func == DPS_P2_LATCH) ? port2_latch : 8'hff;
  assign next_p2_oe_n =
    (p2_func == DPS_P2_STD || p2_func == DPS_P2_LATCH) ? 8'h00
                                                       : 8'hff;

  // Latch strobe: pass only during external activity when suppressed
  assign next_ale = auxiliary_control[DPS_SUPPRESS_BIT]
                  ? (ale_i & (ext_access | ext_code_i))
                  : ale_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      auxiliary_control         <= DPS_REG_RESET;
      port2_extension_control   <= DPS_REG_RESET;
      strobe_pins_low_function  <= DPS_REG_RESET;
      strobe_pins_high_function <= DPS_REG_RESET;
      strobe_port_data          <= DPS_PORT_DATA_RESET;
      port2_enable_address_high <= DPS_REG_RESET;
      port2_enable_address_low  <= DPS_REG_RESET;
      port2_data                <= DPS_P2_DATA_RESET;
    end else if (ce_i && sfr_wr_i) begin
      if (sfr_addr_i == DPS_AUX_CTRL_ADDR)
        auxiliary_control <= sfr_wdata_i & DPS_AUX_MASK;
      else if (sfr_addr_i == DPS_P2_EXT_CTRL_ADDR)
        port2_extension_control <= sfr_wdata_i & DPS_P2_EXT_MASK;
      else if (sfr_addr_i == DPS_FUNC_LOW_ADDR)
        strobe_pins_low_function <= sfr_wdata_i;
      else if (sfr_addr_i == DPS_FUNC_HIGH_ADDR)
        strobe_pins_high_function <= sfr_wdata_i;
      else if (sfr_addr_i == DPS_PORT_DATA_ADDR)
        strobe_port_data <= sfr_wdata_i[3:0];
      else if (sfr_addr_i == DPS_P2_ADDR_HIGH)
        port2_enable_address_high <= sfr_wdata_i;
      else if (sfr_addr_i == DPS_P2_ADDR_LOW)
        port2_enable_address_low <= sfr_wdata_i;
      else if (sfr_addr_i == DPS_P2_DATA_ADDR)
        port2_data <= sfr_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port2_latch <= DPS_REG_RESET;
    end else if (ce_i && p2_latch_load) begin
      port2_latch <= ext_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o       <= 8'h00;
      ext_rdata_o       <= 8'h00;
      ext_hit_o         <= 1'b0;
      ale_o             <= 1'b0;
      strobe_pin_o      <= {NPINS{1'b1}};
      strobe_pin_oe_n_o <= {NPINS{1'b1}};
      ext_int_o         <= 2'b11;
      port2_pins_o      <= 8'hff;
      port2_pins_oe_n_o <= 8'hff;
    end else if (ce_i) begin
      sfr_rdata_o       <= sfr_rd_i ? next_rdata : 8'h00;
      ext_rdata_o       <= port2_pins_i;
      ext_hit_o         <= (p2_func == DPS_P2_BUFFER) & ext_rd_i &
                           p2_addr_hit;
      ale_o             <= next_ale;
      strobe_pin_o      <= next_strobe_pin;
      strobe_pin_oe_n_o <= next_strobe_oe_n;
      ext_int_o         <= strobe_pin_i[3:2];
      port2_pins_o      <= next_p2_pins;
      port2_pins_oe_n_o <= next_p2_oe_n;
    end
  end
endmodule : dps_top

/* File: dps_top_tb_top.sv */
// Purpose: Self-checking bench for dps_top
// Assumes: ce_i dropped once to check the freeze
// Notes:   Peripheral model resolves pin levels
`timescale 1ns/1ps
module dps_top_tb_top;
  import dps_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, erd = 0, ewr = 0;
  logic        code = 0, ale = 0, ce = 1, hit, aleo;
  logic [1:0]  eint;
  logic [7:0]  sa = 0, sd = 0, ed = 0, std2 = 0, rdat, erdat, p2o, p2oe, p2l;
  logic [15:0] ea = 0;
  logic [3:0]  so, soe, sl;
  int          num_errors = 0, checks_done = 0, cycles = 0;
  always #5 clk = ~clk;
  dps_top #(.NPINS(4)) dut (.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .sfr_addr_i(sa), .sfr_wdata_i(sd), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_rdata_o(rdat), .ext_addr_i(ea), .ext_wdata_i(ed), .ext_rd_i(erd),
    .ext_wr_i(ewr), .ext_rdata_o(erdat), .ext_hit_o(hit), .ext_code_i(code),
    .ale_i(ale), .ale_o(aleo), .strobe_pin_i(sl), .strobe_pin_o(so),
    .strobe_pin_oe_n_o(soe), .ext_int_o(eint), .port2_pins_i(p2l),
    .port2_std_i(std2), .port2_pins_o(p2o), .port2_pins_oe_n_o(p2oe));
  dps_periph peri (.p2_oe_n_i(p2oe), .p2_o_i(p2o), .stb_oe_n_i(soe),
    .stb_o_i(so), .p2_lvl_o(p2l), .stb_lvl_o(sl));
  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sa <= a;
    sd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sa <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask : rchk
  task automatic ext(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    ea  <= a;
    ed  <= d;
    erd <= !w;
    ewr <= w;
    @(posedge clk);
    #1;
  endtask : ext
  task automatic idle();
    @(posedge clk);
    erd <= 1'b0;
    ewr <= 1'b0;
  endtask : idle
  always @(posedge clk) begin
    ale <= ~ale;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(DPS_AUX_CTRL_ADDR, 8'h00);
    rchk(DPS_PORT_DATA_ADDR, 8'h0f);
    rchk(8'h00, 8'h00);
    wreg(DPS_BASE_HIGH_ADDR0, 8'h12);
    wreg(DPS_BASE_LOW_ADDR0, 8'h34);
    wreg(DPS_BASE_HIGH_ADDR1, 8'h56);
    wreg(DPS_BASE_HIGH_ADDR2, 8'h12);
    wreg(DPS_BASE_LOW_ADDR2, 8'h34);
    rchk(DPS_BASE_HIGH_ADDR1, 8'h56);
    wreg(DPS_FUNC_LOW_ADDR, 8'h7a);
    wreg(DPS_FUNC_HIGH_ADDR, 8'h0c);
    wreg(DPS_P2_EXT_CTRL_ADDR, 8'h10);
    ext(16'h1237, 1'b1, 8'h00);
    chk({4'h0, so}, 8'h0f);
    idle();
    ext(16'h1238, 1'b1, 8'h00);
    chk({4'h0, so}, 8'h0e);
    idle();
    ext(16'h1234, 1'b0, 8'h00);
    chk({4'h0, so}, 8'h0a);
    idle();
    ext(16'h56ff, 1'b0, 8'h00);
    chk({4'h0, so}, 8'h0c);
    idle();
    wreg(DPS_PORT_DATA_ADDR, 8'ha5);
    @(posedge clk) #1 chk({4'h0, so}, 8'h06);
    chk({4'h0, soe}, 8'h00);
    rchk(DPS_PORT_DATA_ADDR, 8'h06);
    chk({6'h00, eint}, 8'h01);
    wreg(DPS_P2_ADDR_HIGH, 8'h56);
    wreg(DPS_P2_ADDR_LOW, 8'h78);
    @(posedge clk) std2 <= 8'h96;
    @(posedge clk) #1 chk(p2o, 8'h96);
    wreg(DPS_P2_EXT_CTRL_ADDR, 8'h12);
    ext(16'h5678, 1'b1, 8'h55);
    idle();
    ext(16'h5679, 1'b1, 8'h33);
    idle();
    wreg(DPS_P2_DATA_ADDR, 8'haa);
    @(posedge clk) #1 chk(p2o, 8'h55);
    chk(p2oe, 8'h00);
    rchk(DPS_P2_DATA_ADDR, 8'haa);
    wreg(DPS_P2_EXT_CTRL_ADDR, 8'h11);
    ext(16'h5678, 1'b0, 8'h00);
    chk({7'h0, hit}, 8'h01);
    chk(erdat, 8'h3c);
    idle();
    ext(16'h5679, 1'b0, 8'h00);
    chk({7'h0, hit}, 8'h00);
    idle();
    wreg(DPS_AUX_CTRL_ADDR, 8'hff);
    rchk(DPS_AUX_CTRL_ADDR, 8'h01);
    repeat (2) @(posedge clk) #1 chk({7'h0, aleo}, 8'h00);
    ext(16'h0000, 1'b0, 8'h00);
    chk({7'h0, aleo}, {7'h0, ~ale});
    idle();
    @(posedge clk) code <= 1'b1;
    repeat (2) @(posedge clk) #1 chk({7'h0, aleo}, {7'h0, ~ale});
    @(posedge clk) code <= 1'b0;
    repeat (2) @(posedge clk) #1 chk({7'h0, aleo}, 8'h00);
    // Write while frozen must not land
    @(posedge clk) ce <= 1'b0;
    wreg(DPS_AUX_CTRL_ADDR, 8'h00);
    @(posedge clk) ce <= 1'b1;
    rchk(DPS_AUX_CTRL_ADDR, 8'h01);
    complete_run();
  end
endmodule : dps_top_tb_top
